// >>> core/sits_controller.sv
`timescale 1ns/1ps
module sits_controller #(
	parameter int QTR_CYCLES = sits_pkg::QTR_CYC
) (
	input  wire logic       MCLK_I,
	input  wire logic       ARST_N_I,
	sits_i2c_if.controller  LINK,
	input  wire logic       CMD_VALID_I,
	output logic            CMD_READY_O,
	input  wire logic       CMD_READ_I,
	input  wire logic [6:0] CMD_REG_I,
	input  wire logic [2:0] CMD_LEN_I,
	input  wire logic [7:0] WDATA_I,
	output logic [7:0]      RDATA_O,
	output logic            RDATA_VALID_O,
	output logic            DONE_O,
	output logic            NACK_O
);
	typedef enum logic [2:0] {C_IDLE, C_START, C_BYTE, C_RSTART, C_STOP} sits_cst_t;
	typedef enum logic [2:0] {S_ADDR, S_OPC, S_WDATA, S_ADDR_R, S_READ} sits_step_t;

	sits_cst_t  cst;
	sits_step_t step;
	logic [7:0] div;
	logic       tick;
	logic [1:0] q;
	logic [3:0] bi;
	logic [7:0] sh;
	logic       rd;
	logic [2:0] left;
	logic [6:0] reg_a;
	logic [7:0] wbyte;
	logic       ack_n;
	logic       scl_oe;
	logic       sda_oe;

	// quarter-bit enable keeps scl at or below the bus maximum
	assign tick        = (div == 8'(QTR_CYCLES - 1)); // [RULE_18]
	assign CMD_READY_O = (cst == C_IDLE);

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			div <= 8'h0;
		end else if (tick || cst == C_IDLE) begin
			div <= 8'h0;
		end else begin
			div <= div + 8'h1;
		end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			cst           <= C_IDLE;
			step          <= S_ADDR;
			q             <= 2'h0;
			bi            <= 4'h0;
			sh            <= 8'h0;
			rd            <= 1'b0;
			left          <= 3'h0;
			reg_a         <= 7'h0;
			wbyte         <= 8'h0;
			ack_n         <= 1'b0;
			scl_oe        <= 1'b0;
			sda_oe        <= 1'b0;
			RDATA_O       <= 8'h0;
			RDATA_VALID_O <= 1'b0;
			DONE_O        <= 1'b0;
			NACK_O        <= 1'b0;
		end else begin
			RDATA_VALID_O <= 1'b0;
			DONE_O        <= 1'b0;
			if (cst == C_IDLE) begin
				if (CMD_VALID_I) begin
					cst    <= C_START; // [RULE_05]
					q      <= 2'h0;
					rd     <= CMD_READ_I;
					left   <= CMD_LEN_I;
					reg_a  <= CMD_REG_I;
					wbyte  <= WDATA_I;
					NACK_O <= 1'b0;
				end
			end else if (tick) begin
				q <= q + 2'h1;
				unique case (cst)
					C_IDLE: begin
					end
					C_START: begin
						if (q == 2'h1) sda_oe <= 1'b1; // [RULE_06]
						if (q == 2'h2) scl_oe <= 1'b1;
						if (q == 2'h3) begin
							cst  <= C_BYTE;
							step <= S_ADDR;
							sh   <= {sits_pkg::TARGET_ADDR, sits_pkg::DIR_WRITE}; // [RULE_09] [RULE_10]
							bi   <= 4'h0;
						end
					end
					C_BYTE: begin
						if (q == 2'h0) begin
							if (bi == sits_pkg::BYTE_BITS) begin
								sda_oe <= (step == S_READ) && (left != 3'h1); // [RULE_16] [RULE_17]
							end else begin
								sda_oe <= (step != S_READ) && !sh[7]; // [RULE_13]
							end
						end
						if (q == 2'h1) scl_oe <= 1'b0;
						if (q == 2'h2) begin
							if (bi == sits_pkg::BYTE_BITS) begin
								ack_n <= LINK.sda; // [RULE_12]
							end else begin
								sh <= {sh[6:0], LINK.sda}; // [RULE_08]
							end
						end
						if (q == 2'h3) begin
							scl_oe <= 1'b1;
							bi     <= (bi == sits_pkg::BYTE_BITS) ? 4'h0 : bi + 4'h1;
							if (bi == sits_pkg::BYTE_BITS) begin
								unique case (step)
									S_ADDR: begin
										if (ack_n) begin
											NACK_O <= 1'b1;
											cst    <= C_STOP;
										end else begin
											step <= S_OPC;
											sh   <= {1'b0, reg_a}; // [RULE_11]
										end
									end
									S_OPC: begin
										if (ack_n) begin
											NACK_O <= 1'b1;
											cst    <= C_STOP;
										end else if (rd) begin
											cst <= C_RSTART; // [RULE_15]
										end else if (left != 3'h0) begin
											step <= S_WDATA;
											sh   <= wbyte;
										end else begin
											cst <= C_STOP;
										end
									end
									S_WDATA: begin
										NACK_O <= ack_n;
										cst    <= C_STOP;
									end
									S_ADDR_R: begin
										NACK_O <= ack_n;
										if (ack_n || left == 3'h0) begin
											cst <= C_STOP;
										end else begin
											step <= S_READ;
										end
									end
									S_READ: begin
										RDATA_O       <= sh;
										RDATA_VALID_O <= 1'b1;
										left          <= left - 3'h1;
										if (left == 3'h1) cst <= C_STOP;
									end
								endcase
							end
						end
					end
					C_RSTART: begin
						if (q == 2'h0) sda_oe <= 1'b0;
						if (q == 2'h1) scl_oe <= 1'b0;
						if (q == 2'h2) sda_oe <= 1'b1; // [RULE_15]
						if (q == 2'h3) begin
							scl_oe <= 1'b1;
							cst    <= C_BYTE;
							step   <= S_ADDR_R;
							sh     <= {sits_pkg::TARGET_ADDR, sits_pkg::DIR_READ}; // [RULE_10]
						end
					end
					C_STOP: begin
						if (q == 2'h0) sda_oe <= 1'b1;
						if (q == 2'h1) scl_oe <= 1'b0;
						if (q == 2'h2) sda_oe <= 1'b0; // [RULE_07]
						if (q == 2'h3) begin
							cst    <= C_IDLE;
							DONE_O <= 1'b1;
						end
					end
				endcase
			end
		end
	end

	// open-drain: the controller also only pulls low
	assign LINK.ctl_scl_o  = 1'b0;
	assign LINK.ctl_scl_oe = scl_oe;
	assign LINK.ctl_sda_o  = 1'b0;
	assign LINK.ctl_sda_oe = sda_oe;
endmodule

// >>> core/sits_i2c_if.sv
`timescale 1ns/1ps
interface sits_i2c_if;
	logic ctl_scl_o;
	logic ctl_scl_oe;
	logic ctl_sda_o;
	logic ctl_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	// wired-and with pull-ups: a line is low while any enabled driver pulls it low
	assign scl = !(ctl_scl_oe && !ctl_scl_o);
	assign sda = !((ctl_sda_oe && !ctl_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport target (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport controller (input sda, output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe);
endinterface

// >>> core/sits_pkg.sv
package sits_pkg;
	localparam int          CLK_HZ      = 50_000_000;
	localparam int          SCL_HZ      = 100_000;
	localparam int          STARTUP_MS  = 10;
	localparam int          PERIOD_MS   = 200;
	localparam int          CONV_US     = 1000;
	localparam int          STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;
	localparam int          PERIOD_CYC  = CLK_HZ / 1000 * PERIOD_MS;
	localparam int          CONV_CYC    = CLK_HZ / 1_000_000 * CONV_US;
	localparam int          QTR_CYC     = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
	localparam logic [6:0]  TARGET_ADDR = 7'h28;
	localparam logic        DIR_READ    = 1'b1;
	localparam logic        DIR_WRITE   = 1'b0;
	localparam logic        ACK         = 1'b0;
	localparam int          REG_AW      = 3;
	localparam int          REG_COUNT   = 8;
	localparam logic [2:0]  TEMP_BASE   = 3'h0;
	localparam logic [2:0]  HUM_BASE    = 3'h3;
	localparam logic [3:0]  BYTE_BITS   = 4'h8;
endpackage

// >>> core/sits_target.sv
`timescale 1ns/1ps
// Operation
// [RULE_01] target after reset, data valid within 10 ms
// [RULE_02] humidity conversion, then temperature conversion
// [RULE_03] processor writes results after both conversions
// [RULE_04] measurement cycle repeats every 200 ms
// [RULE_05] only the controller starts transfers
// [RULE_06] start: sda falls while scl high
// [RULE_07] stop: sda rises while scl high, idle
// [RULE_08] sample on scl rise, hold while high
// [RULE_09] respond only to address 0x28
// [RULE_10] eighth address bit: 1 read, 0 write
// [RULE_11] write sends opcode with register address first
// [RULE_12] receiver acknowledges each byte by driving low
// [RULE_13] in writes target drives only acknowledge slots
// [RULE_14] opcode register address steers data and reads
// [RULE_15] read needs repeated start with read bit
// [RULE_16] controller nack ends read sending
// [RULE_17] controller ack advances address, next byte sent
// [RULE_18] bus works up to 100 kHz
// [RULE_19] target only pulls sda low or releases
module sits_target #(
	parameter int STARTUP_CYCLES = sits_pkg::STARTUP_CYC,
	parameter int PERIOD_CYCLES  = sits_pkg::PERIOD_CYC,
	parameter int CONV_CYCLES    = sits_pkg::CONV_CYC
) (
	input  wire logic        MCLK_I,
	input  wire logic        ARST_N_I,
	sits_i2c_if.target       LINK,
	input  wire logic [15:0] HUM_RAW_I,
	input  wire logic [15:0] TEMP_RAW_I,
	output logic             HUM_CONV_O,
	output logic             TEMP_CONV_O,
	output logic             DATA_VALID_O
);
	typedef enum logic [1:0] {M_WAIT, M_HUM, M_TEMP, M_CALC} sits_meas_t;
	typedef enum logic [2:0] {T_IDLE, T_ADDR, T_OPC, T_WDATA, T_ACK, T_RDATA, T_RACK} sits_tst_t;

	localparam int AW = sits_pkg::REG_AW;

	sits_meas_t      mst;
	sits_tst_t       tst;
	sits_tst_t       after;
	logic [23:0]     tmr;
	logic [23:0]     lim;
	logic            boot;
	logic            trig;
	logic [15:0]     ccnt;
	logic [15:0]     hum;
	logic [15:0]     temp;
	logic [7:0]      regs [sits_pkg::REG_COUNT];
	logic            scl_q;
	logic            sda_q;
	logic            rise;
	logic            fall;
	logic            start;
	logic            stop;
	logic [3:0]      cnt;
	logic [7:0]      sh;
	logic [7:0]      tx;
	logic [AW-1:0]   ptr;
	logic [AW-1:0]   ptr_nx;
	logic            sda_oe;
	logic            mack;
	logic            rx_state;
	logic            byte_end;
	logic            wr_en;

	// the first cycle is timed to finish just inside the start-up window
	assign lim  = boot ? 24'(STARTUP_CYCLES - 2 * CONV_CYCLES - 2) : 24'(PERIOD_CYCLES); // [RULE_01]
	assign trig = (tmr == lim - 24'h1);

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			tmr  <= 24'h0;
			boot <= 1'b1;
		end else if (trig) begin
			tmr  <= 24'h0; // [RULE_04]
			boot <= 1'b0;
		end else begin
			tmr <= tmr + 24'h1;
		end
	end

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			mst  <= M_WAIT;
			ccnt <= 16'h0;
			hum  <= 16'h0;
			temp <= 16'h0;
		end else begin
			unique case (mst)
				M_WAIT: begin
					if (trig) begin
						mst  <= M_HUM; // [RULE_02]
						ccnt <= 16'h0;
					end
				end
				M_HUM: begin
					if (ccnt == 16'(CONV_CYCLES - 1)) begin
						hum  <= HUM_RAW_I;
						ccnt <= 16'h0;
						mst  <= M_TEMP; // [RULE_02]
					end else begin
						ccnt <= ccnt + 16'h1;
					end
				end
				M_TEMP: begin
					if (ccnt == 16'(CONV_CYCLES - 1)) begin
						temp <= TEMP_RAW_I;
						mst  <= M_CALC; // [RULE_03]
					end else begin
						ccnt <= ccnt + 16'h1;
					end
				end
				M_CALC: begin
					mst <= M_WAIT;
				end
			endcase
		end
	end

	assign HUM_CONV_O  = (mst == M_HUM);
	assign TEMP_CONV_O = (mst == M_TEMP);

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DATA_VALID_O <= 1'b0;
		end else if (mst == M_CALC) begin
			DATA_VALID_O <= 1'b1; // [RULE_01]
		end
	end

	// update beats a same-cycle bus write on result bytes only; free bytes keep the write
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			for (int i = 0; i < sits_pkg::REG_COUNT; i++) begin
				regs[i] <= 8'h0;
			end
		end else begin
			if (wr_en) begin
				regs[ptr] <= sh; // [RULE_14]
			end
			if (mst == M_CALC) begin
				regs[sits_pkg::TEMP_BASE]        <= temp[15:8]; // [RULE_03]
				regs[sits_pkg::TEMP_BASE + 3'h1] <= temp[7:0];
				regs[sits_pkg::TEMP_BASE + 3'h2] <= temp[15:8] + temp[7:0];
				regs[sits_pkg::HUM_BASE]         <= hum[15:8];
				regs[sits_pkg::HUM_BASE + 3'h1]  <= hum[7:0];
				regs[sits_pkg::HUM_BASE + 3'h2]  <= hum[15:8] + hum[7:0];
			end
		end
	end

	// inputs arrive synchronous; one stage gives the previous level for edges
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= LINK.scl;
			sda_q <= LINK.sda;
		end
	end

	assign rise     = LINK.scl && !scl_q; // [RULE_08] [RULE_18]
	assign fall     = !LINK.scl && scl_q;
	assign start    = LINK.scl && scl_q && sda_q && !LINK.sda; // [RULE_06]
	assign stop     = LINK.scl && scl_q && !sda_q && LINK.sda; // [RULE_07]
	assign rx_state = (tst == T_ADDR) || (tst == T_OPC) || (tst == T_WDATA);
	assign byte_end = fall && (cnt == sits_pkg::BYTE_BITS);
	assign wr_en    = byte_end && (tst == T_WDATA) && !start && !stop;
	assign ptr_nx   = ptr + AW'(1);

	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			tst    <= T_IDLE;
			after  <= T_IDLE;
			cnt    <= 4'h0;
			sh     <= 8'h0;
			tx     <= 8'h0;
			ptr    <= '0;
			sda_oe <= 1'b0;
			mack   <= 1'b0;
		end else if (start) begin
			tst    <= T_ADDR; // [RULE_06] [RULE_15]
			cnt    <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop) begin
			tst    <= T_IDLE; // [RULE_07]
			sda_oe <= 1'b0;
		end else if (rise) begin
			if (rx_state && cnt != sits_pkg::BYTE_BITS) begin
				sh  <= {sh[6:0], LINK.sda}; // [RULE_08]
				cnt <= cnt + 4'h1;
			end
			if (tst == T_RDATA) begin
				cnt <= cnt + 4'h1;
			end
			if (tst == T_RACK) begin
				mack <= (LINK.sda == sits_pkg::ACK);
			end
		end else if (fall) begin
			unique case (tst)
				T_IDLE: begin
				end
				T_ADDR: begin
					if (byte_end) begin
						if (sh[7:1] == sits_pkg::TARGET_ADDR) begin // [RULE_09]
							sda_oe <= 1'b1; // [RULE_12]
							tst    <= T_ACK;
							after  <= (sh[0] == sits_pkg::DIR_READ) ? T_RDATA : T_OPC; // [RULE_10]
						end else begin
							tst <= T_IDLE;
						end
					end
				end
				T_OPC: begin
					if (byte_end) begin
						ptr    <= sh[AW-1:0]; // [RULE_14]
						sda_oe <= 1'b1;
						tst    <= T_ACK;
						after  <= T_WDATA;
					end
				end
				T_WDATA: begin
					if (byte_end) begin
						ptr    <= ptr_nx;
						sda_oe <= 1'b1; // [RULE_12]
						tst    <= T_ACK;
						after  <= T_WDATA;
					end
				end
				T_ACK: begin
					cnt <= 4'h0;
					tst <= after;
					if (after == T_RDATA) begin
						tx     <= regs[ptr]; // [RULE_14]
						sda_oe <= !regs[ptr][7];
					end else begin
						sda_oe <= 1'b0; // [RULE_13]
					end
				end
				T_RDATA: begin
					if (cnt == sits_pkg::BYTE_BITS) begin
						sda_oe <= 1'b0;
						tst    <= T_RACK;
					end else begin
						tx     <= {tx[6:0], 1'b0};
						sda_oe <= !tx[6];
					end
				end
				T_RACK: begin
					if (mack) begin
						ptr    <= ptr_nx; // [RULE_17]
						tx     <= regs[ptr_nx];
						sda_oe <= !regs[ptr_nx][7];
						cnt    <= 4'h0;
						tst    <= T_RDATA;
					end else begin
						tst <= T_IDLE; // [RULE_16]
					end
				end
			endcase
		end
	end

	// no scl driver exists here at all: the target never masters the bus
	assign LINK.dev_sda_o  = 1'b0; // [RULE_19] [RULE_05]
	assign LINK.dev_sda_oe = sda_oe;
endmodule

// >>> test/sits_i2c_props.sv
`timescale 1ns/1ps
module sits_i2c_props #(
	parameter int STARTUP_CYCLES = 20,
	parameter int PERIOD_CYCLES  = 40,
	parameter int HALF_CYCLES    = 8
) (
	input wire logic MCLK_I,
	input wire logic ARST_N_I,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic HUM_CONV_O,
	input wire logic TEMP_CONV_O,
	input wire logic DATA_VALID_O
);
	int   up_cnt;
	int   gap;
	int   hold;
	logic seen;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!ARST_N_I);
	sequence bus_start;
		$fell(sda) && scl && $past(scl);
	endsequence
	sequence bus_stop;
		$rose(sda) && scl && $past(scl);
	endsequence
	// saturates one past the limit so the valid check has a single cycle of slack
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			up_cnt <= 0;
		end else if (up_cnt <= STARTUP_CYCLES) begin
			up_cnt <= up_cnt + 1;
		end
	end
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			gap  <= 0;
			seen <= 1'b0;
		end else if ($rose(HUM_CONV_O)) begin
			gap  <= 1;
			seen <= 1'b1;
		end else begin
			gap <= gap + 1;
		end
	end
	// cycles the scl level has stood; starts full so the first edge after reset is not judged
	always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			hold <= HALF_CYCLES;
		end else if ($changed(scl)) begin
			hold <= 1;
		end else begin
			hold <= hold + 1;
		end
	end
	chk_no_drive_high: assert property (dev_sda_oe |-> dev_sda_o == 1'b0)
		else $error("target drives sda high");
	chk_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("target sda changed while scl high");
	chk_ack_after_fall: assert property ($rose(dev_sda_oe) |-> !$past(scl) && $past(scl, 2))
		else $error("target pull not one cycle after scl fall");
	chk_stop_release: assert property (bus_stop |=> !dev_sda_oe [*8])
		else $error("target drives after stop");
	chk_start_listen: assert property (bus_start |=> !dev_sda_oe [*8])
		else $error("target drives during address");
	chk_temp_follows: assert property ($fell(HUM_CONV_O) |-> TEMP_CONV_O)
		else $error("temperature conversion did not follow");
	chk_update_after: assert property ($fell(TEMP_CONV_O) |-> ##[1:3] DATA_VALID_O)
		else $error("no result update after conversions");
	chk_valid_source: assert property ($rose(DATA_VALID_O) |-> $past(TEMP_CONV_O, 2) && !$past(TEMP_CONV_O))
		else $error("data valid not right after conversions");
	chk_meas_period: assert property ($rose(HUM_CONV_O) && seen |-> gap == PERIOD_CYCLES)
		else $error("measurement period wrong");
	chk_startup_valid: assert property (up_cnt > STARTUP_CYCLES |-> DATA_VALID_O)
		else $error("data not valid after start-up");
	chk_scl_rate: assert property ($changed(scl) |-> hold >= HALF_CYCLES)
		else $error("scl level shorter than half bit");
	cover property (bus_start ##[1:300] $rose(dev_sda_oe));
	cover property (bus_stop);
	cover property ($fell(TEMP_CONV_O));
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int CONV    = 4;
	localparam int STARTUP = 20;
	localparam int PERIOD  = 40;
	localparam int QTR     = 4;
	logic        mclk       = 1'b0;
	logic        arst_n     = 1'b0;
	logic        cmd_valid  = 1'b0;
	logic        cmd_read   = 1'b0;
	logic [6:0]  cmd_reg    = 7'h00;
	logic [2:0]  cmd_len    = 3'h0;
	logic [7:0]  wdata      = 8'h00;
	logic [15:0] hum_raw    = 16'h0000;
	logic [15:0] temp_raw   = 16'h0000;
	logic [31:0] rng        = 32'h166D9E1D;
	logic [7:0]  free6      = 8'h00;
	logic [7:0]  free7      = 8'h00;
	logic        cmd_ready;
	logic        rdata_valid;
	logic        done;
	logic        nack;
	logic        data_valid;
	logic        hum_conv;
	logic        temp_conv;
	logic [7:0]  rdata;
	logic [7:0]  got[$];
	int          failures   = 0;
	int          n_compared = 0;
	always #10 mclk = ~mclk;
	sits_i2c_if sits_i2c_if_i ();
	sits_target #(.STARTUP_CYCLES(STARTUP), .PERIOD_CYCLES(PERIOD), .CONV_CYCLES(CONV)) sits_target_i (
		.MCLK_I(mclk), .ARST_N_I(arst_n), .LINK(sits_i2c_if_i.target), .HUM_RAW_I(hum_raw),
		.TEMP_RAW_I(temp_raw), .HUM_CONV_O(hum_conv), .TEMP_CONV_O(temp_conv), .DATA_VALID_O(data_valid));
	sits_controller #(.QTR_CYCLES(QTR)) sits_controller_i (
		.MCLK_I(mclk), .ARST_N_I(arst_n), .LINK(sits_i2c_if_i.controller), .CMD_VALID_I(cmd_valid),
		.CMD_READY_O(cmd_ready), .CMD_READ_I(cmd_read), .CMD_REG_I(cmd_reg), .CMD_LEN_I(cmd_len),
		.WDATA_I(wdata), .RDATA_O(rdata), .RDATA_VALID_O(rdata_valid), .DONE_O(done), .NACK_O(nack));
	sits_i2c_props #(.STARTUP_CYCLES(STARTUP), .PERIOD_CYCLES(PERIOD), .HALF_CYCLES(2 * QTR)) sits_i2c_props_i (
		.MCLK_I(mclk), .ARST_N_I(arst_n), .scl(sits_i2c_if_i.scl), .sda(sits_i2c_if_i.sda),
		.dev_sda_o(sits_i2c_if_i.dev_sda_o), .dev_sda_oe(sits_i2c_if_i.dev_sda_oe),
		.HUM_CONV_O(hum_conv), .TEMP_CONV_O(temp_conv),
		.DATA_VALID_O(data_valid));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// checksum bytes truncate to eight bits, giving the sum mod 256
	function automatic logic [7:0] exp_byte(input logic [2:0] idx);
		case (idx)
			3'h0: return temp_raw[15:8];
			3'h1: return temp_raw[7:0];
			3'h2: return temp_raw[15:8] + temp_raw[7:0];
			3'h3: return hum_raw[15:8];
			3'h4: return hum_raw[7:0];
			3'h5: return hum_raw[15:8] + hum_raw[7:0];
			3'h6: return free6;
			default: return free7;
		endcase
	endfunction
	task automatic test_done();
		if (failures == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
		n_compared++;
		if (seen !== want) begin
			failures++;
			$display("[FAIL] %0t %s: got %h want %h", $time, what, seen, want);
		end
	endtask
	task automatic timeout(input string what);
		failures++;
		$display("[FAIL] %0t timeout %s", $time, what);
		test_done();
	endtask
	task automatic run_cmd(input logic rd, input logic [6:0] rg, input logic [2:0] len, input logic [7:0] wd);
		int i;
		got.delete();
		i = 0;
		@(negedge mclk);
		while (cmd_ready !== 1'b1) begin
			i++;
			if (i > 5000) timeout("ready");
			@(negedge mclk);
		end
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_read  <= rd;
		cmd_reg   <= rg;
		cmd_len   <= len;
		wdata     <= wd;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		do begin
			@(negedge mclk);
			if (rdata_valid === 1'b1) got.push_back(rdata);
			i++;
			if (i > 20000) timeout("done");
		end while (done !== 1'b1);
		check(8'(nack), 8'h00, "target ack");
	endtask
	task automatic read_check(input logic [2:0] base, input logic [2:0] len);
		run_cmd(1'b1, {4'h0, base}, len, 8'h00);
		check(8'(got.size()), 8'(len), "byte count");
		for (int k = 0; k < got.size() && k < len; k++) begin
			check(got[k], exp_byte(base + 3'(k)), "read byte");
		end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(negedge mclk);
		check(8'(data_valid), 8'h00, "valid at start");
		for (int n = 0; n < 4; n++) begin
			rng = xorshift(rng);
			@(posedge mclk);
			temp_raw <= (n == 0) ? 16'hFFFF : rng[15:0];
			hum_raw  <= (n == 0) ? 16'h80FF : rng[31:16];
			rng = xorshift(rng);
			free6 = rng[7:0];
			free7 = rng[15:8];
			run_cmd(1'b0, 7'h06, 3'h1, free6);
			run_cmd(1'b0, 7'h07, 3'h1, free7);
			// opcode-only write must leave the register untouched
			run_cmd(1'b0, 7'h06, 3'h0, ~free6);
			repeat (2 * PERIOD) @(posedge mclk);
			check(8'(data_valid), 8'h01, "valid");
			read_check(sits_pkg::TEMP_BASE, 3'h6);
			read_check(sits_pkg::HUM_BASE, 3'h3);
			read_check(3'h6, 3'h3);
			read_check(3'h7, 3'h1);
		end
		test_done();
	end
endmodule
